//--- rtl/spi_fifo_data_path.sv
// FIFO data path of a serial peripheral: queues, flags, sequencing, packing.
`timescale 1ns/100ps
`default_nettype none
`include "spi_fifo_regs.svh"

module spi_fifo_data_path (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire logic peripheral_enable_i,
  input wire logic master_mode_i,
  input wire logic receive_only_select_i,
  input wire logic single_line_mode_i,
  input wire logic single_line_output_enable_i,
  input wire logic crc_enable_i,
  input wire logic [3:0] frame_size_i,
  input wire logic rx_threshold_select_i,
  input wire logic serial_data_port_wr_i,
  input wire logic serial_data_port_rd_i,
  input wire logic serial_data_port_half_i,
  input wire logic [15:0] serial_data_port_wdata_i,
  output logic [15:0] serial_data_port_rdata_o,
  output logic [1:0] tx_queue_level_o,
  output logic [1:0] rx_queue_level_o,
  output logic rx_ready_flag_o,
  output logic tx_space_flag_o,
  output logic overrun_flag_o,
  input wire logic overrun_clear_i,
  output logic transfer_busy_flag_o,
  input wire logic slave_select_line_n_i,
  input wire logic rx_line_i,
  output logic tx_line_o,
  output logic clock_run_o
);
  import spi_fifo_pkg::*;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Frame length in bits; codes below the minimum fall back to a byte
  function automatic logic [4:0] frame_len(input logic [3:0] ds);
    frame_len = (ds < `FRAME_CODE_MIN) ? `FRAME_FORCED : {1'b0, ds} + 5'd1;
  endfunction : frame_len

  // Byte count to two-bit level; three bytes already read as full
  function automatic logic [1:0] level_of(input logic [2:0] cnt);
    case (cnt)
      3'd0: level_of = `LEVEL_EMPTY;
      3'd1: level_of = `LEVEL_QUARTER;
      3'd2: level_of = `LEVEL_HALF;
      default: level_of = `LEVEL_FULL;
    endcase
  endfunction : level_of

  // ------------------------------------------------------------
  // Register-side state and decode
  // ------------------------------------------------------------
  core_state_t r;         // Registered state
  core_state_t r_nxt;     // Next state
  link_state_t lk;        // Link-side state
  link_state_t lk_nxt;

  logic wide;             // Frame needs two bytes
  logic rx_only;          // Any receive-only mode
  logic bypass;           // Queue reduced to one frame
  logic [2:0] fr_n;       // Bytes per frame
  logic [2:0] rx_need;    // Bytes that make the threshold
  logic [2:0] acc_n;      // Bytes per data port access
  logic rx_ready;
  logic rd_ok;            // Read is served
  logic wr_ok;            // Write is taken
  logic ld_ok;            // Queue head moves to stage
  logic rx_edge;          // Link finished a frame
  logic rx_fit;
  logic [2:0] rx_left;    // Receive bytes after this cycle's read

  assign wide = frame_len(frame_size_i) > `FRAME_BYTE_MAX;
  assign rx_only = receive_only_select_i | (single_line_mode_i & ~single_line_output_enable_i);
  assign bypass = rx_only & crc_enable_i;
  assign fr_n = wide ? `TWO_BYTES : `ONE_BYTE;
  assign acc_n = (wide | serial_data_port_half_i) ? `TWO_BYTES : `ONE_BYTE;
  assign rx_need = (wide | ~rx_threshold_select_i) ? `TWO_BYTES : `ONE_BYTE;
  assign rx_ready = r.rx_cnt >= rx_need;
  assign rd_ok = serial_data_port_rd_i & rx_ready & (r.rx_cnt >= acc_n);
  assign tx_space_flag_o = r.tx_cnt <= `TX_SPACE_MAX;
  // Any accepted write fits: at most two bytes stored plus two new
  assign wr_ok = serial_data_port_wr_i & tx_space_flag_o;
  assign ld_ok = ~r.req & ~r.ack_s2 & (r.tx_cnt >= fr_n);
  assign rx_edge = r.tg_s2 ^ r.tg_s3;
  assign rx_left = rd_ok ? r.rx_cnt - acc_n : r.rx_cnt;
  // Bypass trades the queue for a single frame slot
  assign rx_fit = (rx_left + fr_n) <= (bypass ? fr_n : `QUEUE_BYTES);

  // ------------------------------------------------------------
  // Register-side next state
  // ------------------------------------------------------------
  // Queue pushes, pops, staging handshake and flags
  always_comb begin
    r_nxt = r;
    r_nxt.ack_s1 = lk.ack;
    r_nxt.ack_s2 = r.ack_s1;
    r_nxt.busy_s1 = lk.busy;
    r_nxt.busy_s2 = r.busy_s1;
    r_nxt.tg_s1 = lk.tg;
    r_nxt.tg_s2 = r.tg_s1;
    r_nxt.tg_s3 = r.tg_s2;
    // Data port read: oldest bytes, low byte first
    if (rd_ok) begin
      r_nxt.rdata = (acc_n == `TWO_BYTES) ? {r.rx_q[r.rx_rp + 2'd1], r.rx_q[r.rx_rp]}
                                          : {8'h00, r.rx_q[r.rx_rp]};
      r_nxt.rx_rp = r.rx_rp + acc_n[1:0];
    end
    // Data port write appends at the tail
    if (wr_ok) begin
      r_nxt.tx_q[r.tx_wp] = serial_data_port_wdata_i[7:0];
      if (acc_n == `TWO_BYTES) begin
        r_nxt.tx_q[r.tx_wp + 2'd1] = serial_data_port_wdata_i[15:8];
      end
      r_nxt.tx_wp = r.tx_wp + acc_n[1:0];
    end
    // Queue head moves to the stage offered to the link
    if (ld_ok) begin
      r_nxt.stage = wide ? {r.tx_q[r.tx_rp + 2'd1], r.tx_q[r.tx_rp]} : {8'h00, r.tx_q[r.tx_rp]};
      r_nxt.tx_rp = r.tx_rp + fr_n[1:0];
      r_nxt.req = 1'b1;
    end else if (r.ack_s2) begin
      r_nxt.req = 1'b0;
    end
    r_nxt.tx_cnt = r.tx_cnt + (wr_ok ? acc_n : 3'd0) - (ld_ok ? fr_n : 3'd0);
    // Received frame enters the queue or is dropped as overrun
    if (overrun_clear_i) begin
      r_nxt.overrun_flag = 1'b0;
    end
    if (rx_edge && rx_fit) begin
      r_nxt.rx_q[r.rx_wp] = lk.hold[7:0];
      if (wide) begin
        r_nxt.rx_q[r.rx_wp + 2'd1] = lk.hold[15:8];
      end
      r_nxt.rx_wp = r.rx_wp + fr_n[1:0];
      r_nxt.rx_cnt = rx_left + fr_n;
    end else begin
      r_nxt.rx_cnt = rx_left;
      // Set wins over a clear in the same cycle
      if (rx_edge) begin
        r_nxt.overrun_flag = 1'b1;
      end
    end
  end

  // Register-side flops; disable touches nothing here, so unread data stays
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  // Status outputs from flops; the ready flag also uses the threshold select and frame size inputs
  assign serial_data_port_rdata_o = r.rdata;
  assign tx_queue_level_o = level_of(r.tx_cnt);
  assign rx_queue_level_o = level_of(r.rx_cnt);
  assign rx_ready_flag_o = rx_ready;
  assign overrun_flag_o = r.overrun_flag;
  // A staged frame counts as a transfer still under way
  assign transfer_busy_flag_o = r.busy_s2 | r.req;

  // ------------------------------------------------------------
  // Link-side logic
  // ------------------------------------------------------------
  logic [4:0] llen;       // Frame length seen by the link
  logic active;           // A bit is exchanged this edge
  logic last;             // This edge samples the final bit
  logic take;             // A new staged frame may be taken
  logic bound;            // Frame boundary: next frame may be loaded

  assign llen = frame_len(lk.ds_s2);
  assign active = lk.mst_s2 ? lk.run : (lk.en_s2 & ~lk.sel_n_s2);
  assign last = active & (5'(lk.cnt + 5'd1) == llen);
  // An idle master is never mid-frame, even with a frame left loaded from slave role
  assign bound = last | (~active & (~lk.txv | lk.mst_s2));
  assign take = lk.req_s2 & ~lk.ack & lk.en_s2 & ~lk.rxo_s2;

  // Shifting, frame completion and master clock sequencing
  always_comb begin
    lk_nxt = lk;
    lk_nxt.rst_s1 = reset_i;
    lk_nxt.rst_s2 = lk.rst_s1;
    lk_nxt.req_s1 = r.req;
    lk_nxt.req_s2 = lk.req_s1;
    lk_nxt.en_s1 = peripheral_enable_i;
    lk_nxt.en_s2 = lk.en_s1;
    lk_nxt.rxo_s1 = rx_only;
    lk_nxt.rxo_s2 = lk.rxo_s1;
    lk_nxt.mst_s1 = master_mode_i;
    lk_nxt.mst_s2 = lk.mst_s1;
    lk_nxt.sel_n_s1 = slave_select_line_n_i;
    lk_nxt.sel_n_s2 = lk.sel_n_s1;
    // Frame size is static while enabled, so two flops suffice
    lk_nxt.ds_s1 = frame_size_i;
    lk_nxt.ds_s2 = lk.ds_s1;
    // Four-phase return: drop ack once the request is gone
    if (lk.ack && !lk.req_s2) begin
      lk_nxt.ack = 1'b0;
    end
    // Bit exchange
    if (active) begin
      lk_nxt.sh_rx = {lk.sh_rx[14:0], rx_line_i};
      lk_nxt.sh_tx = {lk.sh_tx[14:0], 1'b0};
      lk_nxt.cnt = 5'(lk.cnt + 5'd1);
      lk_nxt.busy = 1'b1;
      if (last) begin
        lk_nxt.hold = {lk.sh_rx[14:0], rx_line_i};
        lk_nxt.tg = ~lk.tg;
        lk_nxt.cnt = 5'd0;
        lk_nxt.txv = 1'b0;
        lk_nxt.busy = 1'b0;
      end
    end
    // Load next outgoing frame left-aligned; none means zeros go out
    if (bound) begin
      if (take) begin
        lk_nxt.sh_tx = 16'(r.stage << (`FRAME_WORD - llen));
        lk_nxt.ack = 1'b1;
        lk_nxt.txv = 1'b1;
      end else if (last) begin
        lk_nxt.sh_tx = 16'h0000;
      end
      // Master decides at each boundary whether the clock keeps running
      if (!lk.mst_s2) begin
        lk_nxt.run = 1'b0;
      end else if (lk.rxo_s2) begin
        lk_nxt.run = lk.en_s2;
      end else begin
        lk_nxt.run = take;
      end
      // Master busy stays up across back-to-back frames
      if (lk.mst_s2) begin
        lk_nxt.busy = lk_nxt.run;
      end
    end
    // Reset arrives through the synchroniser
    if (lk.rst_s2) begin
      lk_nxt.run = 1'b0;
      lk_nxt.busy = 1'b0;
      lk_nxt.ack = 1'b0;
      lk_nxt.txv = 1'b0;
      lk_nxt.tg = 1'b0;
      lk_nxt.cnt = 5'd0;
      lk_nxt.sh_tx = 16'h0000;
      lk_nxt.sh_rx = 16'h0000;
      lk_nxt.hold = 16'h0000;
    end
  end

  // Link flops; the link clock may stand still when the partner is master
  always_ff @(posedge link_clk_i) begin
    lk <= lk_nxt;
  end

  assign tx_line_o = lk.sh_tx[15];
  assign clock_run_o = lk.run;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_rx_frame_in;
    rx_edge && rx_fit && !rd_ok;
  endsequence

  sequence s_rx_count_up;
    r.rx_cnt == $past(r.rx_cnt) + $past(fr_n);
  endsequence

  sequence s_master_tx_end;
    last && lk.mst_s2 && !lk.rxo_s2 && !take && !lk.rst_s2;
  endsequence

  sequence s_receive_only_select_idle;
    lk.mst_s2 && lk.rxo_s2 && lk.en_s2 && !lk.run && !lk.rst_s2;
  endsequence

  tx_space_level_a: assert property (@(posedge clk_i) disable iff (reset_i)
    tx_space_flag_o |-> tx_queue_level_o != `LEVEL_FULL)
    else $error("transmit space shown with full level");

  tx_three_full_a: assert property (@(posedge clk_i) disable iff (reset_i)
    r.tx_cnt == 3'd3 |-> tx_queue_level_o == `LEVEL_FULL && !tx_space_flag_o)
    else $error("three queued bytes not reported full");

  write_append_a: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_ok && !ld_ok |=> r.tx_cnt == $past(r.tx_cnt) + $past(acc_n))
    else $error("accepted write not appended");

  frame_store_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_rx_frame_in |=> s_rx_count_up)
    else $error("completed frame not stored");

  overrun_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rx_edge && !rx_fit |=> overrun_flag_o ##1 (overrun_flag_o || $past(overrun_clear_i)))
    else $error("overrun not flagged");

  read_empty_a: assert property (@(posedge clk_i) disable iff (reset_i)
    serial_data_port_rd_i && !rx_ready |=> r.rx_cnt >= $past(r.rx_cnt))
    else $error("read below threshold popped data");

  disable_keep_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !peripheral_enable_i && !rd_ok |=> r.rx_cnt >= $past(r.rx_cnt))
    else $error("disabled queue lost data");

  reset_clear_a: assert property (@(posedge clk_i)
    reset_i |=> r.rx_cnt == 3'd0 && r.tx_cnt == 3'd0 && !overrun_flag_o)
    else $error("reset left queue state");

  master_stop_a: assert property (@(posedge link_clk_i) disable iff (lk.rst_s2)
    s_master_tx_end |=> !clock_run_o)
    else $error("master clock kept running without data");

  receive_only_select_start_a: assert property (@(posedge link_clk_i) disable iff (lk.rst_s2)
    s_receive_only_select_idle |=> clock_run_o)
    else $error("receive-only master did not start");

  slave_gap_a: assert property (@(posedge link_clk_i) disable iff (lk.rst_s2)
    last && !lk.mst_s2 |=> !lk.busy)
    else $error("slave busy without gap");

endmodule : spi_fifo_data_path

`default_nettype wire

//--- rtl/spi_fifo_pkg.sv
// State types of the serial FIFO data path.
`default_nettype none
package spi_fifo_pkg;

  // Register-side state
  typedef struct packed {
    logic [3:0][7:0] tx_q;  // Transmit queue bytes
    logic [3:0][7:0] rx_q;  // Receive queue bytes
    logic [1:0] tx_wp;
    logic [1:0] tx_rp;
    logic [2:0] tx_cnt;
    logic [1:0] rx_wp;
    logic [1:0] rx_rp;
    logic [2:0] rx_cnt;
    logic [15:0] rdata;     // Last read word
    logic [15:0] stage;     // Frame offered to the link
    logic req;              // Stage holds a frame
    logic overrun_flag;              // Sticky overrun
    logic ack_s1;
    logic ack_s2;
    logic busy_s1;
    logic busy_s2;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
  } core_state_t;

  // Link-side state
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic en_s1;
    logic en_s2;
    logic rxo_s1;
    logic rxo_s2;
    logic mst_s1;
    logic mst_s2;
    logic sel_n_s1;
    logic sel_n_s2;
    logic [3:0] ds_s1;
    logic [3:0] ds_s2;
    logic [15:0] sh_tx;     // Outgoing shift register, MSB leaves first
    logic [15:0] sh_rx;     // Incoming shift register
    logic [15:0] hold;      // Completed received frame
    logic [4:0] cnt;        // Bits done in this frame
    logic txv;              // Outgoing shift register is loaded
    logic ack;
    logic tg;               // Toggles per received frame
    logic run;              // Master clock running
    logic busy;
  } link_state_t;

endpackage : spi_fifo_pkg
`default_nettype wire

//--- rtl/spi_fifo_regs.svh
// Constants of the serial FIFO data path: capacities, level codes, frame sizes.
`ifndef SPI_FIFO_REGS_SVH
`define SPI_FIFO_REGS_SVH

// ------------------------------------------------------------
// Queue geometry
// ------------------------------------------------------------
`define QUEUE_BYTES 3'd4
`define TX_SPACE_MAX 3'd2
`define ONE_BYTE 3'd1
`define TWO_BYTES 3'd2

// ------------------------------------------------------------
// Two-bit level codes
// ------------------------------------------------------------
`define LEVEL_EMPTY 2'b00
`define LEVEL_QUARTER 2'b01
`define LEVEL_HALF 2'b10
`define LEVEL_FULL 2'b11

// ------------------------------------------------------------
// Frame size
// ------------------------------------------------------------
`define FRAME_CODE_MIN 4'h3
`define FRAME_FORCED 5'd8
`define FRAME_BYTE_MAX 5'd8
`define FRAME_WORD 5'd16

`endif

//--- test/spi_fifo_data_path_bench.sv
// Self-checking bench of the serial FIFO data path in master role.
`timescale 1ns/100ps
`default_nettype none

module spi_fifo_data_path_bench;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clk_i = 0, reset_i = 1, link_clk = 0, en = 0, rxo = 0, thr = 1;
  logic wr = 0, rd = 0, half = 0, ovr_clr = 0, run_l = 0, slm = 0, crc = 0;
  logic [3:0] fsz = 4'h7; // Byte frames
  logic [15:0] wdata = 16'h0000, rdata, d;
  logic [1:0] tx_lvl, rx_lvl;
  logic rdy, space, overrun_flag, busy, txl, run, miso;
  wire logic sclk;
  int fails = 0, n_compared = 0, k, base;

  spi_fifo_data_path u_spi_fifo_data_path (
    .clk_i(clk_i), .reset_i(reset_i), .link_clk_i(link_clk),
    .peripheral_enable_i(en), .master_mode_i(1'b1), .receive_only_select_i(rxo),
    .single_line_mode_i(slm), .single_line_output_enable_i(1'b0), .crc_enable_i(crc),
    .frame_size_i(fsz), .rx_threshold_select_i(thr), .serial_data_port_wr_i(wr),
    .serial_data_port_rd_i(rd), .serial_data_port_half_i(half),
    .serial_data_port_wdata_i(wdata), .serial_data_port_rdata_o(rdata),
    .tx_queue_level_o(tx_lvl), .rx_queue_level_o(rx_lvl), .rx_ready_flag_o(rdy),
    .tx_space_flag_o(space), .overrun_flag_o(overrun_flag), .overrun_clear_i(ovr_clr),
    .transfer_busy_flag_o(busy), .slave_select_line_n_i(1'b1), .rx_line_i(miso),
    .tx_line_o(txl), .clock_run_o(run)
  );

  // Gate latched on the low phase so the partner never sees a runt pulse
  always @(negedge link_clk) run_l <= (run === 1'b1);
  assign sclk = link_clk & run_l;

  spi_slave_model u_spi_slave_model (.sclk_i(sclk), .mosi_i(txl), .miso_o(miso));

  // ------------------------------------------------------------
  // Clocks: 8 ns core, 125 ns link with an unrelated phase
  // ------------------------------------------------------------
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #31;
    forever #62.5 link_clk = ~link_clk;
  end

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("compared=%0d mismatches=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic dwrite(input logic [15:0] v, input logic h);
    @(negedge clk_i);
    wr = 1;
    wdata = v;
    half = h;
    @(negedge clk_i);
    wr = 0;
  endtask : dwrite

  // Read data is a register, so look one cycle after the strobe
  task automatic dread(input logic h, output logic [15:0] v);
    @(negedge clk_i);
    rd = 1;
    half = h;
    @(negedge clk_i);
    rd = 0;
    cyc(1);
    v = rdata;
  endtask : dread

  // Link quiet: nothing queued, nothing staged, clock stopped
  task automatic wait_idle;
    cyc(4);
    for (k = 0; k < 4000 && (busy !== 1'b0 || run !== 1'b0 || tx_lvl !== 2'b00); k++) cyc(1);
    if (k == 4000) begin
      fails++;
      stop_test;
    end
    cyc(10);
  endtask : wait_idle

  // Receive-only master: starts unprompted, stopped by a disable in its third frame
  task automatic rx_only_run;
    base = u_spi_slave_model.n_frames;
    en = 1;
    for (k = 0; k < 200 && run !== 1'b1; k++) cyc(1);
    if (k == 200) begin
      fails++;
      stop_test;
    end
    cyc(300);
    en = 0; // Inside the third frame: it completes, no more follow
    wait_idle;
    chk(u_spi_slave_model.n_frames - base, 16'h0003);
    cyc(200);
    chk(run, 1'b0);
  endtask : rx_only_run

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(50); // Long enough for three link edges under reset
    reset_i = 0;
    cyc(1);
    chk({7'h0, tx_lvl, rx_lvl, rdy, space, overrun_flag, busy, run}, 16'h0008);
    dread(1'b1, d);
    chk(d, 16'h0000);
    // Fill the transmit side while disabled; first byte goes to the stage
    dwrite(16'h0011, 1'b0);
    cyc(3);
    chk({tx_lvl, busy}, 3'b001);
    dwrite(16'h0022, 1'b0);
    dwrite(16'h0033, 1'b0);
    dwrite(16'h0044, 1'b0);
    cyc(1);
    chk({tx_lvl, space}, 3'b110);
    dwrite(16'h0055, 1'b0);
    cyc(1);
    chk({tx_lvl, space}, 3'b110);
    en = 1;
    wait_idle;
    for (int i = 0; i < 4; i++) chk(u_spi_slave_model.log_q[i], 8'h11 * (i + 1));
    chk({rx_lvl, rdy, run}, 4'b1110);
    en = 0; // Only after transmit level 00 and busy clear
    cyc(20);
    chk(rx_lvl, 2'b11);
    en = 1;
    dwrite(16'h0066, 1'b0);
    wait_idle;
    chk(overrun_flag, 1'b1);
    ovr_clr = 1;
    cyc(1);
    ovr_clr = 0;
    cyc(1);
    chk(overrun_flag, 1'b0);
    for (int i = 0; i < 4; i++) begin
      dread(1'b0, d);
      chk(d, 16'h0050 + i);
    end
    chk({rx_lvl, rdy}, 3'b000);
    // Packed pair with the sixteen-bit threshold
    thr = 0;
    dwrite(16'h040a, 1'b1);
    wait_idle;
    chk(u_spi_slave_model.log_q[5], 8'h0a);
    chk(u_spi_slave_model.log_q[6], 8'h04);
    chk({rx_lvl, rdy}, 3'b101);
    dread(1'b1, d);
    chk(d, 16'h5655);
    // Odd byte, with a short size code that acts as eight bits
    fsz = 4'h2;
    dwrite(16'h0077, 1'b0);
    wait_idle;
    chk({rx_lvl, rdy}, 3'b010);
    thr = 1;
    cyc(2);
    chk(rdy, 1'b1);
    dread(1'b0, d);
    chk(d, 16'h0057);
    // Receive-only master runs with no data queued
    rxo = 1;
    rx_only_run;
    chk(rx_lvl, 2'b11);
    for (int i = 0; i < 3; i++) begin
      dread(1'b0, d);
      chk(d, 16'h0058 + i);
    end
    rxo = 0;
    // Single-line receive with check on: one frame slot, later frames overrun
    slm = 1;
    crc = 1;
    rx_only_run;
    chk({rx_lvl, rdy, overrun_flag}, 4'b0111);
    dread(1'b0, d);
    chk(d, 16'h005b);
    slm = 0;
    crc = 0;
    // Sixteen-bit frame: one word each way, high byte first on the line
    fsz = 4'hf;
    en = 1;
    dwrite(16'h1234, 1'b1);
    wait_idle;
    chk(u_spi_slave_model.log_q[14], 8'h12);
    chk(u_spi_slave_model.log_q[15], 8'h34);
    chk({rx_lvl, rdy}, 3'b101);
    dread(1'b1, d);
    chk(d, 16'h5e5f);
    en = 0;
    fsz = 4'h7;
    // Reset with data pending clears everything
    dwrite(16'h0099, 1'b0);
    dwrite(16'h0088, 1'b0);
    cyc(2);
    reset_i = 1;
    cyc(50);
    reset_i = 0;
    cyc(1);
    chk({7'h0, tx_lvl, rx_lvl, rdy, space, overrun_flag, busy, run}, 16'h0008);
    stop_test;
  end
endmodule : spi_fifo_data_path_bench
`default_nettype wire

//--- test/spi_slave_model.sv
// Remote serial slave that answers the master data path on the link.
`timescale 1ns/100ps
`default_nettype none

module spi_slave_model (
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o
);
  // ------------------------------------------------------------
  // Shift state
  // ------------------------------------------------------------
  logic [7:0] out_sh = 8'h50; // Frame being shifted out, MSB first
  logic [7:0] in_sh = 8'h00; // Frame being taken from the master
  logic [2:0] bit_cnt = 3'h0; // Bits done in the current frame
  int n_frames = 0; // Frames completed so far
  logic [7:0] log_q [0:63]; // Frames taken from the master, in order

  // Always has data ready; the master takes it whether or not it was wanted
  assign miso_o = out_sh[7];

  // Sample on the rising edge, the same edge the master samples on
  always @(posedge sclk_i) begin
    in_sh = {in_sh[6:0], mosi_i};
    bit_cnt = bit_cnt + 3'h1;
    if (bit_cnt == 3'h0) begin
      log_q[n_frames[5:0]] = in_sh;
      n_frames = n_frames + 1;
    end
  end

  // Launch on the falling edge so the master never samples a changing line
  always @(negedge sclk_i) begin
    if (bit_cnt == 3'h0) begin
      out_sh <= 8'h50 + n_frames[7:0];
    end else begin
      out_sh <= {out_sh[6:0], 1'b0};
    end
  end
endmodule : spi_slave_model
`default_nettype wire
